// file: rtl/dac_front_pkg.sv
// Constants shared by the dual converter digital front end
package dac_front_pkg;
    // Register addresses on the serial port
    localparam logic [4:0] ADDR_DATA_CTRL = 5'h02;
    localparam logic [4:0] ADDR_MEM_CTRL  = 5'h12;
    localparam logic [4:0] ADDR_CLK_MODE  = 5'h14;
    localparam logic [4:0] ADDR_VERSION   = 5'h1F;
    // Data control fields
    localparam int DC_EDGE_BIT  = 4;
    localparam int DC_ORDER_BIT = 5;
    localparam int DC_TWOS_BIT  = 7;
    localparam logic [7:0] DATA_CTRL_RESET = 8'h00;
    // Memory control fields
    localparam int MC_QCLR_BIT   = 7;
    localparam int MC_ICLR_BIT   = 6;
    localparam int MC_CAL_BIT    = 4;
    localparam int MC_STORE_BIT  = 3;
    localparam int MC_LOAD_BIT   = 2;
    localparam int MC_QUNCAL_BIT = 1;
    localparam int MC_IUNCAL_BIT = 0;
    // Clock mode fields
    localparam int CM_QPH_LSB  = 6;
    localparam int CM_SRCH_BIT = 4;
    localparam int CM_REACQ_BIT = 3;
    localparam int CM_OVR_BIT  = 2;
    localparam int CM_IPH_LSB  = 0;
    localparam logic [1:0] PHASE_RESET = 2'b00;
    // Retimer search length in core clock cycles
    localparam int SEARCH_CYCLES = 128;
    // Serial frame: 8 instruction bits then 8 data bits
    localparam logic [3:0] SPI_LAST_BIT  = 4'hF;
    localparam logic [3:0] SPI_INSTR_END = 4'h7;
    // Synchroniser depth for outside inputs
    localparam int SYNC_STAGES = 3;
endpackage

// file: rtl/dac_front.sv
// Serial register port, DDR sample capture and retimer control
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - A one written to the start bit fires one self-calibration start pulse.
// R2 - A one written to the store bit fires one coefficient store pulse.
// R3 - A one written to the load bit fires one coefficient load pulse.
// R4 - A one written to the Q uncalibrate bit resets Q coefficients.
// R5 - A one written to the I uncalibrate bit resets I coefficients.
// R6 - Q phase field reads retimer choice, or is writable under override.
// R7 - I phase field reads retimer choice, or is writable under override.
// R8 - Searching flag reads one while acquiring, zero once locked.
// R9 - Only a zero to one change of reacquire restarts acquisition.
// R10 - Under override the I phase field drives both retimers.
// R11 - Without override each retimer exposes the phase picked from one shared level measurement.
// R12 - Read-only register at 0x1F returns the hardware version.
// R13 - I and Q share one DDR bus, one sample per data clock edge.
// R14 - Bus carries up to 250 MSPS with a 125 MHz data clock.
// R15 - Order bit picks first channel, edge bit picks capture edge.
// R16 - Format bit selects unsigned or twos complement input samples.
// R17 - Sample bus width is a parameter, top bit index 7 to 13.
// R18 - Edge select is bit 4, order bit 5, of register 0x02.
// R19 - After reset a phase is chosen within 128 cycles, flag clears.
// R20 - Software writes the same forced phase to both fields.
// R21 - Calibration action bits are one-shot, one action per written one.
// R22 - Searching sets on every acquisition start, clears on selection.
module dac_front
    import dac_front_pkg::*;
#(
    parameter int         SAMPLE_W = 14,     // [R17]
    parameter logic [7:0] VERSION  = 8'h5A   // Arbitrary value
)(
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire logic                spi_sclk,
    input  wire logic                spi_cs_n,
    input  wire logic                spi_sdi,
    output logic                     spi_sdo,
    output logic                     spi_sdo_oe,
    input  wire logic                data_clock,
    input  wire logic                converter_clock,
    input  wire logic [SAMPLE_W-1:0] sample_bus,
    output logic                     input_ready,
    output logic                     pair_valid,
    input  wire logic                pair_ready,
    output logic [SAMPLE_W-1:0]      i_sample,
    output logic [SAMPLE_W-1:0]      q_sample,
    output logic                     searching,
    output logic [1:0]               i_phase_sel,
    output logic [1:0]               q_phase_sel,
    output logic                     cal_start_pulse,
    output logic                     coef_store_pulse,
    output logic                     coef_load_pulse,
    output logic                     q_uncal_pulse,
    output logic                     i_uncal_pulse,
    output logic                     q_calstat_clr_pulse,
    output logic                     i_calstat_clr_pulse
);
    localparam int NIN = 5 + SAMPLE_W;
    localparam logic [6:0] SEARCH_LAST = 7'(SEARCH_CYCLES - 1);

    typedef enum logic [0:0] {
        RT_SEARCH = 1'b0,
        RT_LOCKED = 1'b1
    } rt_state_t;

    // Outside inputs gathered for one synchroniser array
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    logic [NIN-1:0] st_q;
    logic [NIN-1:0] prev_q;
    assign raw_in = {sample_bus, converter_clock, data_clock,
                     spi_sdi, spi_cs_n, spi_sclk};

    // Three stages; a level counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NIN; g++)
        begin : g_sync
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    // Select rests high, so its stages start high too
                    s1_q[g]   <= (g == 1) ? 1'b1 : 1'b0;
                    s2_q[g]   <= (g == 1) ? 1'b1 : 1'b0;
                    s3_q[g]   <= (g == 1) ? 1'b1 : 1'b0;
                    st_q[g]   <= (g == 1) ? 1'b1 : 1'b0;
                    prev_q[g] <= (g == 1) ? 1'b1 : 1'b0;
                end
                else
                begin
                    s1_q[g]   <= raw_in[g];
                    s2_q[g]   <= s1_q[g];
                    s3_q[g]   <= s2_q[g];
                    prev_q[g] <= st_q[g];
                    if (s2_q[g] == s3_q[g])
                        st_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    // Named views of the filtered inputs
    wire sclk_rise = st_q[0] & ~prev_q[0];
    wire sclk_fall = ~st_q[0] & prev_q[0];
    wire cs_n      = st_q[1];
    wire sdi       = st_q[2];
    wire dclk_rise = st_q[3] & ~prev_q[3];
    wire dclk_fall = ~st_q[3] & prev_q[3];
    wire conv_lvl  = st_q[4];
    wire [SAMPLE_W-1:0] bus_val = st_q[NIN-1:5];

    // Serial port state
    logic [3:0]  bitcnt_q;
    logic [14:0] shreg_q;
    logic [7:0]  rdsh_q;
    logic        rd_act_q;
    logic        sdo_q;
    // Register state
    logic [7:0]  data_ctrl_q;
    logic        override_q;
    logic        reacq_q;
    logic        reacq_prev_q;
    logic [1:0]  i_force_q;
    logic [1:0]  q_force_q;
    logic [1:0]  i_auto_q;
    logic [1:0]  q_auto_q;
    logic [7:0]  pulse_q;

    // Frame decode on each sampled serial clock rise
    wire [15:0] word     = {shreg_q, sdi};
    wire        bit_take = sclk_rise & ~cs_n;
    wire        wr_fire  = bit_take & (bitcnt_q == SPI_LAST_BIT) & ~word[15];
    wire        rd_start = bit_take & (bitcnt_q == SPI_INSTR_END) & word[7];
    wire [4:0]  wr_addr  = word[12:8];
    wire [7:0]  wr_data  = word[7:0];
    wire [4:0]  rd_addr  = word[4:0];

    // Phase readback: own choice, or forced value under override
    wire [1:0] i_read = override_q ? i_force_q : i_auto_q;   // [R7] [R11]
    wire [1:0] q_read = override_q ? q_force_q : q_auto_q;   // [R6] [R11]

    // Read data selection
    wire [7:0] clk_mode_rd = {q_read, 1'b0, searching, reacq_q,
                              override_q, i_read};            // [R8]
    wire [7:0] rd_data =
        (rd_addr == ADDR_DATA_CTRL) ? data_ctrl_q :
        (rd_addr == ADDR_CLK_MODE)  ? clk_mode_rd :
        (rd_addr == ADDR_VERSION)   ? VERSION     :           // [R12]
                                      8'h00;

    // Register writes decoded
    wire wr_dc = wr_fire & (wr_addr == ADDR_DATA_CTRL);
    wire wr_mc = wr_fire & (wr_addr == ADDR_MEM_CTRL);
    wire wr_cm = wr_fire & (wr_addr == ADDR_CLK_MODE);

    // Serial shift and read-back path
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bitcnt_q <= 4'h0;
            shreg_q  <= 15'h0000;
            rdsh_q   <= 8'h00;
            rd_act_q <= 1'b0;
            sdo_q    <= 1'b0;
        end
        else if (cs_n)
        begin
            bitcnt_q <= 4'h0;
            rd_act_q <= 1'b0;
        end
        else
        begin
            if (bit_take)
            begin
                shreg_q  <= word[14:0];
                bitcnt_q <= bitcnt_q + 4'h1;
            end
            if (rd_start)
            begin
                rdsh_q   <= rd_data;
                rd_act_q <= 1'b1;
            end
            else if (sclk_fall & rd_act_q)
            begin
                sdo_q  <= rdsh_q[7];
                rdsh_q <= {rdsh_q[6:0], 1'b0};
            end
        end
    end
    assign spi_sdo    = sdo_q;
    assign spi_sdo_oe = rd_act_q & ~cs_n;

    // Control registers; phase fields take writes only under override
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            data_ctrl_q <= DATA_CTRL_RESET;
            override_q  <= 1'b0;
            reacq_q     <= 1'b0;
            i_force_q   <= PHASE_RESET;
            q_force_q   <= PHASE_RESET;
        end
        else
        begin
            if (wr_dc)
                data_ctrl_q <= wr_data;                      // [R18]
            if (wr_cm)
            begin
                override_q <= wr_data[CM_OVR_BIT];
                reacq_q    <= wr_data[CM_REACQ_BIT];
                if (wr_data[CM_OVR_BIT])
                begin
                    i_force_q <= wr_data[CM_IPH_LSB +: 2];   // [R7]
                    q_force_q <= wr_data[CM_QPH_LSB +: 2];   // [R6] [R20]
                end
            end
        end
    end

    // One-shot calibration actions, never held while bit stays set
    wire [7:0] pulse_d = wr_mc ? wr_data : 8'h00;             // [R21]
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pulse_q <= 8'h00;
        else
            pulse_q <= pulse_d;
    end
    assign cal_start_pulse     = pulse_q[MC_CAL_BIT];         // [R1]
    assign coef_store_pulse    = pulse_q[MC_STORE_BIT];       // [R2]
    assign coef_load_pulse     = pulse_q[MC_LOAD_BIT];        // [R3]
    assign q_uncal_pulse       = pulse_q[MC_QUNCAL_BIT];      // [R4]
    assign i_uncal_pulse       = pulse_q[MC_IUNCAL_BIT];      // [R5]
    assign q_calstat_clr_pulse = pulse_q[MC_QCLR_BIT];
    assign i_calstat_clr_pulse = pulse_q[MC_ICLR_BIT];

    // Retimer: measure converter clock level at both data clock edges
    rt_state_t   rt_state_q;
    logic [6:0]  rt_cnt_q;
    logic        lvl_rise_q;
    logic        lvl_fall_q;
    wire reacq_edge = reacq_q & ~reacq_prev_q;                // [R9]

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rt_state_q   <= RT_SEARCH;
            rt_cnt_q     <= 7'h00;
            reacq_prev_q <= 1'b0;
            lvl_rise_q   <= 1'b0;
            lvl_fall_q   <= 1'b0;
            i_auto_q     <= PHASE_RESET;
            q_auto_q     <= PHASE_RESET;
        end
        else
        begin
            reacq_prev_q <= reacq_q;
            if (dclk_rise)
                lvl_rise_q <= conv_lvl;
            if (dclk_fall)
                lvl_fall_q <= conv_lvl;
            case (rt_state_q)
                RT_SEARCH:
                begin
                    rt_cnt_q <= rt_cnt_q + 7'h01;
                    if (rt_cnt_q == SEARCH_LAST)             // [R19]
                    begin
                        rt_state_q <= RT_LOCKED;             // [R22]
                        i_auto_q   <= {lvl_rise_q, lvl_fall_q};
                        q_auto_q   <= {lvl_rise_q, lvl_fall_q};
                    end
                end
                RT_LOCKED:
                begin
                    if (reacq_edge)
                    begin
                        rt_state_q <= RT_SEARCH;             // [R9] [R22]
                        rt_cnt_q   <= 7'h00;
                    end
                end
                default:
                    rt_state_q <= RT_SEARCH;
            endcase
        end
    end
    assign searching   = (rt_state_q == RT_SEARCH);           // [R8] [R22]
    assign i_phase_sel = override_q ? i_force_q : i_auto_q;   // [R10] [R11]
    assign q_phase_sel = override_q ? i_force_q : q_auto_q;   // [R10] [R11]

    // DDR capture: first word on the chosen edge, second on the other
    wire edge_sel  = data_ctrl_q[DC_EDGE_BIT];
    wire first_i   = data_ctrl_q[DC_ORDER_BIT];
    wire twos      = data_ctrl_q[DC_TWOS_BIT];
    wire first_ev  = edge_sel ? dclk_rise : dclk_fall;        // [R15]
    wire second_ev = edge_sel ? dclk_fall : dclk_rise;        // [R13]
    logic [SAMPLE_W-1:0] first_q;
    logic                have_first_q;

    // Twos complement input turned to offset binary by its sign bit
    wire [SAMPLE_W-1:0] fmt_mask = {twos, {(SAMPLE_W-1){1'b0}}};
    wire [SAMPLE_W-1:0] cur_fmt  = bus_val ^ fmt_mask;        // [R16]
    wire [SAMPLE_W-1:0] pair_i   = first_i ? first_q : cur_fmt;
    wire [SAMPLE_W-1:0] pair_q   = first_i ? cur_fmt : first_q;
    wire                push     = second_ev & have_first_q & ~searching;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            first_q      <= '0;
            have_first_q <= 1'b0;
        end
        else if (first_ev)
        begin
            first_q      <= cur_fmt;                          // [R14]
            have_first_q <= 1'b1;
        end
        else if (second_ev)
            have_first_q <= 1'b0;
    end

    // Two-entry pair buffer
    logic [2*SAMPLE_W-1:0] buf_mem [0:1];
    logic                  wr_ptr_q;
    logic                  rd_ptr_q;
    logic [1:0]            count_q;
    wire do_push = push & input_ready;
    wire do_pop  = pair_valid & pair_ready;
    assign input_ready = (count_q != 2'd2);
    assign pair_valid  = (count_q != 2'd0);
    assign {i_sample, q_sample} = buf_mem[rd_ptr_q];

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
            wr_ptr_q   <= 1'b0;
            rd_ptr_q   <= 1'b0;
            count_q    <= 2'd0;
        end
        else
        begin
            if (do_push)
            begin
                buf_mem[wr_ptr_q] <= {pair_i, pair_q};
                wr_ptr_q          <= ~wr_ptr_q;
            end
            if (do_pop)
                rd_ptr_q <= ~rd_ptr_q;
            if (do_push & ~do_pop)
                count_q <= count_q + 2'd1;
            else if (do_pop & ~do_push)
                count_q <= count_q - 2'd1;
        end
    end
endmodule
`default_nettype wire

// file: tb/ddr_source.sv
// Model of the controller driving the interleaved DDR sample bus
`timescale 1ns/10ps
`default_nettype none
module ddr_source #(
    parameter int SAMPLE_W = 14
)(
    input  wire logic           core_clk,
    output logic                data_clock,
    output logic [SAMPLE_W-1:0] sample_bus
);
    // Clock rests low and the bus is parked until the first pair
    initial
    begin
        data_clock = 1'b0;
        sample_bus = '0;
    end
    // Word set up two cycles ahead of its edge, 200 ns period
    task automatic edge_out(input logic [SAMPLE_W-1:0] w);
        sample_bus = w;
        repeat (2) @(negedge core_clk);
        data_clock = ~data_clock;
        repeat (2) @(negedge core_clk);
    endtask
    // One pair; a priming edge first if the clock rests wrong
    task automatic send_pair(input logic rise1,
                             input logic [SAMPLE_W-1:0] w1, w2);
        if (data_clock == rise1)
            edge_out(~w1);
        edge_out(w1);
        edge_out(w2);
        sample_bus = ~w2; // Hold over, stale word inverted
        @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/dac_front_checker.sv
// Port assertions for the converter front end
`timescale 1ns/10ps
`default_nettype none
module dac_front_checker
    import dac_front_pkg::*;
#(
    parameter int SAMPLE_W = 14
)(
    input wire logic                core_clk,
    input wire logic                nrst,
    input wire logic                input_ready,
    input wire logic                pair_valid,
    input wire logic                pair_ready,
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic [SAMPLE_W-1:0] q_sample,
    input wire logic                searching,
    input wire logic                cal_start_pulse,
    input wire logic                coef_store_pulse,
    input wire logic                coef_load_pulse,
    input wire logic                q_uncal_pulse,
    input wire logic                i_uncal_pulse
);
    logic [7:0] srch_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Consecutive cycles spent searching
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            srch_q <= 8'h00;
        else if (!searching)
            srch_q <= 8'h00;
        else if (srch_q != 8'hFF)
            srch_q <= srch_q + 8'h01;
    end
    // Strobes last one cycle
    chk_cal_once: assert property (
        cal_start_pulse |=> !cal_start_pulse) else $error("cal strobe held");
    chk_store_once: assert property (
        coef_store_pulse |=> !coef_store_pulse) else $error("store held");
    chk_load_once: assert property (
        coef_load_pulse |=> !coef_load_pulse) else $error("load held");
    chk_quncal_once: assert property (
        q_uncal_pulse |=> !q_uncal_pulse) else $error("q uncal held");
    chk_iuncal_once: assert property (
        i_uncal_pulse |=> !i_uncal_pulse) else $error("i uncal held");
    // Search lasts the documented span
    chk_search_len: assert property (
        $fell(searching) |-> srch_q >= 8'h7F && srch_q <= 8'h81)
        else $error("search length wrong");
    chk_search_max: assert property (
        searching |-> srch_q <= 8'h82) else $error("search too long");
    // Head pair holds while stalled; full implies data waiting
    chk_pair_hold: assert property (
        pair_valid && !pair_ready |=>
        pair_valid && $stable({i_sample, q_sample}))
        else $error("head pair changed under stall");
    chk_full_valid: assert property (
        !input_ready |-> pair_valid) else $error("full without data");
    cov_pop: cover property (pair_valid && pair_ready);
    cov_lock: cover property ($fell(searching));
    cov_full: cover property (!input_ready);
    cov_cal: cover property (cal_start_pulse);
endmodule
bind dac_front dac_front_checker #(.SAMPLE_W(SAMPLE_W)) dac_front_checker_i (
    .core_clk(core_clk), .nrst(nrst), .input_ready(input_ready),
    .pair_valid(pair_valid), .pair_ready(pair_ready),
    .i_sample(i_sample), .q_sample(q_sample), .searching(searching),
    .cal_start_pulse(cal_start_pulse), .coef_store_pulse(coef_store_pulse),
    .coef_load_pulse(coef_load_pulse), .q_uncal_pulse(q_uncal_pulse),
    .i_uncal_pulse(i_uncal_pulse)
);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the converter front end
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import dac_front_pkg::*;
;
    localparam int         W   = 14;
    localparam logic [7:0] VER = 8'h5A; // Arbitrary value
    logic core_clk, nrst, spi_sclk, spi_cs_n, spi_sdi, pair_ready, rdy_en;
    wire  spi_sdo, spi_sdo_oe, data_clock, input_ready, pair_valid, searching;
    wire  [W-1:0] sample_bus, i_sample, q_sample;
    wire  [1:0]   i_phase_sel, q_phase_sel;
    wire  [7:0]   pv;
    logic [2:0]   cc;
    logic [31:0]  seed, e, exp_q[$];
    logic [7:0]   r, mc[9];
    int           n_errors, total_checks, pc[8], pb[8], k;
    assign pv[5] = 1'b0;
    dac_front #(.SAMPLE_W(W), .VERSION(VER)) dac_front_i (
        .core_clk(core_clk), .nrst(nrst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .data_clock(data_clock),
        .converter_clock(cc[2]),
        .sample_bus(sample_bus), .input_ready(input_ready),
        .pair_valid(pair_valid), .pair_ready(pair_ready),
        .i_sample(i_sample), .q_sample(q_sample), .searching(searching),
        .i_phase_sel(i_phase_sel), .q_phase_sel(q_phase_sel),
        .cal_start_pulse(pv[4]), .coef_store_pulse(pv[3]),
        .coef_load_pulse(pv[2]), .q_uncal_pulse(pv[1]),
        .i_uncal_pulse(pv[0]), .q_calstat_clr_pulse(pv[7]),
        .i_calstat_clr_pulse(pv[6])
    );
    ddr_source #(.SAMPLE_W(W)) ddr_source_i (.core_clk(core_clk),
        .data_clock(data_clock), .sample_bus(sample_bus));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Serial frame, MSB first, 400 ns serial clock period
    task automatic spi(input logic rd, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, 2'b00, a, d};
        q = 8'h00;
        spi_cs_n = 1'b0;
        repeat (8) @(negedge core_clk);
        for (int i = 15; i >= 0; i--)
        begin
            spi_sdi = f[i];
            repeat (8) @(negedge core_clk);
            if (i < 8)
            begin
                q[i] = spi_sdo;
                check(spi_sdo_oe, rd);
            end
            spi_sclk = 1'b1;
            repeat (8) @(negedge core_clk);
            spi_sclk = 1'b0;
        end
        spi_cs_n = 1'b1;
        repeat (8) @(negedge core_clk);
        check(spi_sdo_oe, 0);
    endtask
    // Send one random pair, noting the expected output if it is kept
    task automatic send(input logic e1, od, tw, keep);
        logic [2*W-1:0] x;
        x = od ? {seed[W-1:0], seed[31:32-W]} : {seed[31:32-W], seed[W-1:0]};
        x[W-1] ^= tw;
        x[2*W-1] ^= tw;
        if (keep)
            exp_q.push_back(x);
        ddr_source_i.send_pair(e1, seed[W-1:0], seed[31:32-W]);
    endtask
    task automatic settle();
        k = 0;
        while (searching !== 1'b0 && k < 300)
        begin
            @(negedge core_clk);
            k++;
        end
        check(k >= 100 && k <= 140, 1);
    endtask
    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Converter clock, random ready, strobe counts
    always @(negedge core_clk)
    begin
        cc <= cc + 3'h1;
        seed <= lfsr(seed);
        pair_ready <= rdy_en & seed[5];
        for (int b = 0; b < 8; b++)
            pc[b] <= pc[b] + pv[b];
    end
    // Pop the oldest note for each accepted pair
    always @(posedge core_clk)
        if (pair_valid === 1'b1 && pair_ready === 1'b1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            check({4'h0, i_sample, q_sample}, e);
        end
    // Watchdog
    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
    initial
    begin
        mc = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80, 8'h00, 8'hFF};
        {n_errors, total_checks, cc} = '0;
        pc = '{default: 0};
        seed = 32'h0001_5EBC;
        {nrst, spi_sclk, spi_sdi, pair_ready, rdy_en} = '0;
        spi_cs_n = 1'b1;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        settle();
        // Version, write to read-only, unmapped, status readback
        spi(1, ADDR_VERSION, 8'h00, r);
        check(r, VER);
        spi(0, ADDR_VERSION, 8'hFF, r);
        spi(1, ADDR_VERSION, 8'h00, r);
        check(r, VER);
        spi(1, 5'h05, 8'h00, r);
        check(r, 0);
        spi(1, ADDR_CLK_MODE, 8'h00, r);
        // Data clock idles during the first search, so both picks are 00
        check(r, 8'h00);
        check({q_phase_sel, i_phase_sel}, 0);
        // Each action strobe alone, none, and all together
        foreach (mc[j])
        begin
            pb = pc;
            spi(0, ADDR_MEM_CTRL, mc[j], r);
            repeat (4) @(negedge core_clk);
            for (int b = 0; b < 8; b++)
            begin
                k = pc[b] - pb[b];
                check(k, mc[j][b] && b != 5);
            end
        end
        // All four capture timings in both number formats
        rdy_en = 1'b1;
        for (int m = 0; m < 8; m++)
        begin
            spi(0, ADDR_DATA_CTRL, {m[2], 1'b0, m[1:0], 4'h0}, r);
            repeat (4) send(m[0], m[1], m[2], 1);
        end
        // Fill with the reader stalled, one refused, then drain
        repeat (20) @(negedge core_clk);
        rdy_en = 1'b0;
        repeat (2) @(negedge core_clk);
        send(1, 1, 1, 1);
        send(1, 1, 1, 1);
        repeat (6) @(negedge core_clk);
        check(input_ready, 0);
        send(1, 1, 1, 0);
        rdy_en = 1'b1;
        repeat (30) @(negedge core_clk);
        check(exp_q.size(), 0);
        // Forced phase; the I field then steers both retimers
        spi(0, ADDR_CLK_MODE, 8'h86, r);
        check({q_phase_sel, i_phase_sel}, 4'hA);
        spi(0, ADDR_CLK_MODE, 8'h44, r);
        check({q_phase_sel, i_phase_sel}, 4'h0);
        spi(1, ADDR_CLK_MODE, 8'h00, r);
        check(r, 8'h44);
        // Reacquire only on a rising write of its bit
        spi(0, ADDR_CLK_MODE, 8'h08, r);
        settle();
        spi(0, ADDR_CLK_MODE, 8'h08, r);
        check(searching, 0);
        spi(0, ADDR_CLK_MODE, 8'h00, r);
        spi(0, ADDR_CLK_MODE, 8'h08, r);
        check(searching, 1);
        settle();
        conclude();
    end
endmodule
`default_nettype wire
